// [clk_sleep_chk.sv]
// assertions on the ports of the clock, sleep and wakeup controller
`timescale 1ns/1ps
module clk_sleep_chk #(
  parameter [1:0] HIGH_CLK_OPT = 2'h0,
  parameter       P0_W         = 8,
  parameter       WAKE_CLKS    = 4096
) (
  input wire            clk_in,
  input wire            rstn_in,
  input wire            rst_pin_n_in,
  input wire [P0_W-1:0] p0_pins_in,
  input wire [5:0]      p1_pins_in,
  input wire            s_axi_bvalid_out,
  input wire            s_axi_bready_in,
  input wire [1:0]      s_axi_bresp_out,
  input wire            osc_run_out,
  input wire            cpu_run_out,
  input wire            cpu_cycle_out,
  input wire            fcpu_clk_out,
  input wire            int_enable_out,
  input wire            xin_direct_clk_out,
  input wire            crystal_output_pin_gpio_out,
  input wire            osc_high_drive_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  reg [15:0]     warm_r;   // warm-up cycles since oscillator restart
  reg            slept_r;  // a sleep was seen since last run
  reg [3:0]      quiet_r;  // cycles since any pin changed
  reg [P0_W+6:0] pins_r;   // previous pin levels
  // ---------------------------------------------
  // helper counters
  // ---------------------------------------------
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      warm_r <= 16'h0000;
      slept_r <= 1'b0;
      quiet_r <= 4'hF;
      pins_r <= {1'b1, {P0_W{1'b0}}, 6'h00};
    end else begin
      warm_r <= !osc_run_out ? 16'h0000 : warm_r + {15'h0000, !cpu_run_out};
      slept_r <= !osc_run_out | (slept_r & !cpu_run_out);
      pins_r <= {rst_pin_n_in, p0_pins_in, p1_pins_in};
      quiet_r <= (pins_r != {rst_pin_n_in, p0_pins_in, p1_pins_in}) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hF};
    end
  end
  sequence s_cycle_gap;
    !cpu_cycle_out [*3];
  endsequence
  sequence s_pin_low;
    !rst_pin_n_in [*6];
  endsequence
  a_cycle_every_four: assert property (cpu_cycle_out |=> s_cycle_gap) else $error("cycle spacing");
  a_cycle_needs_run: assert property (cpu_cycle_out |-> cpu_run_out) else $error("cycle outside run");
  a_sleep_halts_all: assert property (!osc_run_out |-> !cpu_run_out && !fcpu_clk_out) else $error("active asleep");
  a_int_follows_run: assert property (int_enable_out == cpu_run_out) else $error("interrupt gate");
  a_warm_length: assert property ($rose(cpu_run_out) && slept_r |-> warm_r == WAKE_CLKS) else $error("warm count");
  a_wake_has_cause: assert property ($rose(osc_run_out) |-> quiet_r < 4'h8) else $error("wake w/o pin");
  a_crystal_output_pin_freed: assert property ($past(rstn_in) |-> crystal_output_pin_gpio_out == (HIGH_CLK_OPT == 2'h0)) else $error("crystal_output_pin");
  a_xin_direct: assert property ($past(rstn_in) |-> xin_direct_clk_out == (HIGH_CLK_OPT == 2'h0)) else $error("xin");
  a_drive_option: assert property ($past(rstn_in) |-> osc_high_drive_out == (HIGH_CLK_OPT == 2'h1)) else $error("drive");
  a_rst_pin_stops: assert property (s_pin_low |=> !cpu_run_out) else $error("reset pin ignored");
  a_bresp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("bresp dropped");
endmodule
bind clk_sleep_ctrl clk_sleep_chk #(.HIGH_CLK_OPT(HIGH_CLK_OPT), .P0_W(P0_W), .WAKE_CLKS(WAKE_CLKS)) u_chk (
  .clk_in(clk_in), .rstn_in(rstn_in), .rst_pin_n_in(rst_pin_n_in), .p0_pins_in(p0_pins_in),
  .p1_pins_in(p1_pins_in), .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_bresp_out(s_axi_bresp_out), .osc_run_out(osc_run_out), .cpu_run_out(cpu_run_out),
  .cpu_cycle_out(cpu_cycle_out), .fcpu_clk_out(fcpu_clk_out), .int_enable_out(int_enable_out),
  .xin_direct_clk_out(xin_direct_clk_out), .crystal_output_pin_gpio_out(crystal_output_pin_gpio_out), .osc_high_drive_out(osc_high_drive_out));

// [clk_sleep_ctrl.v]
// clock division, sleep entry and pin wakeup controller with axi4-lite registers
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "clk_sleep_defs.vh"

module clk_sleep_ctrl #(
  parameter [1:0] HIGH_CLK_OPT = `OPT_4M,
  parameter       P0_W         = 8,
  parameter       WAKE_CLKS    = `WAKE_CLKS
) (
  input  wire                  clk_in,
  input  wire                  rstn_in,
  input  wire                  rst_pin_n_in,
  input  wire [P0_W-1:0]       p0_pins_in,
  input  wire [`P1W_BITS-1:0]  p1_pins_in,
  input  wire [11:0]           s_axi_awaddr_in,
  input  wire                  s_axi_awvalid_in,
  output reg                   s_axi_awready_out,
  input  wire [31:0]           s_axi_wdata_in,
  input  wire [3:0]            s_axi_wstrb_in,
  input  wire                  s_axi_wvalid_in,
  output reg                   s_axi_wready_out,
  output reg  [1:0]            s_axi_bresp_out,
  output reg                   s_axi_bvalid_out,
  input  wire                  s_axi_bready_in,
  input  wire [11:0]           s_axi_araddr_in,
  input  wire                  s_axi_arvalid_in,
  output reg                   s_axi_arready_out,
  output reg  [31:0]           s_axi_rdata_out,
  output reg  [1:0]            s_axi_rresp_out,
  output reg                   s_axi_rvalid_out,
  input  wire                  s_axi_rready_in,
  output reg                   osc_run_out,
  output reg                   cpu_run_out,
  output reg                   cpu_cycle_out,
  output reg                   fcpu_clk_out,
  output reg                   int_enable_out,
  output reg                   xin_direct_clk_out,
  output reg                   crystal_output_pin_gpio_out,
  output reg                   osc_high_drive_out
);

  // ---------------------------------------------------------------
  // mode states
  // ---------------------------------------------------------------
  localparam [1:0] ST_RESET = 2'h0;  // reset pin held low
  localparam [1:0] ST_WARM  = 2'h1;  // oscillator settling
  localparam [1:0] ST_RUN   = 2'h2;  // normal mode
  localparam [1:0] ST_SLEEP = 2'h3;  // power-down mode

  localparam [12:0] WAKE_LAST = WAKE_CLKS[12:0] - 13'h0001;  // last settle count, cut to counter width

  reg  [1:0]            state_r;      // current mode
  reg  [1:0]            state_nxt;    // next mode
  reg  [12:0]           warm_cnt_r;   // settling counter
  reg  [1:0]            div_r;        // divide-by-four phase
  reg                   sleep_r;      // sleep request bit
  reg  [`P1W_BITS-1:0]  p1w_r;        // port 1 wake enables
  reg                   t0_en_r;      // timer0 enable bit
  reg  [7:0]            t0_cnt_r;     // timer0 counter

  // ---------------------------------------------------------------
  // reset pin and wake pin synchronisers
  // ---------------------------------------------------------------
  reg  [2:0]            rpin_s_r;     // reset pin sync chain
  reg                   rpin_lvl_r;   // filtered reset pin level
  reg  [P0_W-1:0]       p0_s1_r;      // port 0 first stage
  reg  [P0_W-1:0]       p0_s2_r;      // port 0 second stage
  reg  [P0_W-1:0]       p0_s3_r;      // port 0 third stage
  reg  [P0_W-1:0]       p0_lvl_r;     // port 0 accepted level
  reg  [`P1W_BITS-1:0]  p1_s1_r;      // port 1 first stage
  reg  [`P1W_BITS-1:0]  p1_s2_r;      // port 1 second stage
  reg  [`P1W_BITS-1:0]  p1_s3_r;      // port 1 third stage
  reg  [`P1W_BITS-1:0]  p1_lvl_r;     // port 1 accepted level

  wire [P0_W-1:0]       p0_agree;     // stages two and three match
  wire [`P1W_BITS-1:0]  p1_agree;     // stages two and three match
  wire [P0_W-1:0]       p0_chg;       // accepted port 0 change
  wire [`P1W_BITS-1:0]  p1_chg;       // accepted port 1 change
  wire                  wake;         // any enabled wake trigger
  wire                  ext_rst;      // reset pin seen low

  assign p0_agree = ~(p0_s2_r ^ p0_s3_r);
  assign p1_agree = ~(p1_s2_r ^ p1_s3_r);
  assign p0_chg   = p0_agree & (p0_s3_r ^ p0_lvl_r);
  assign p1_chg   = p1_agree & (p1_s3_r ^ p1_lvl_r);
  // port 0 always armed, port 1 gated per pin
  assign wake     = (|p0_chg) | (|(p1_chg & p1w_r));
  assign ext_rst  = ~rpin_lvl_r;

  // three flops; a change counts once stages two and three agree
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rpin_s_r   <= 3'h0;
      rpin_lvl_r <= 1'b0;
      p0_s1_r    <= {P0_W{1'b0}};
      p0_s2_r    <= {P0_W{1'b0}};
      p0_s3_r    <= {P0_W{1'b0}};
      p0_lvl_r   <= {P0_W{1'b0}};
      p1_s1_r    <= `RST_P1W;
      p1_s2_r    <= `RST_P1W;
      p1_s3_r    <= `RST_P1W;
      p1_lvl_r   <= `RST_P1W;
    end else begin
      rpin_s_r <= {rpin_s_r[1:0], rst_pin_n_in};
      if (rpin_s_r[1] == rpin_s_r[2]) begin
        rpin_lvl_r <= rpin_s_r[2];
      end
      p0_s1_r  <= p0_pins_in;
      p0_s2_r  <= p0_s1_r;
      p0_s3_r  <= p0_s2_r;
      p0_lvl_r <= (p0_lvl_r & ~p0_agree) | (p0_s3_r & p0_agree);
      p1_s1_r  <= p1_pins_in;
      p1_s2_r  <= p1_s1_r;
      p1_s3_r  <= p1_s2_r;
      p1_lvl_r <= (p1_lvl_r & ~p1_agree) | (p1_s3_r & p1_agree);
    end
  end

  // ---------------------------------------------------------------
  // mode state machine
  // ---------------------------------------------------------------
  // next mode from reset pin, sleep bit, wake pins and settle count
  always @* begin
    state_nxt = state_r;
    if (ext_rst) begin
      state_nxt = ST_RESET;
    end else begin
      case (state_r)
        ST_RESET: begin
          state_nxt = ST_WARM;
        end
        ST_WARM: begin
          if (warm_cnt_r == WAKE_LAST) begin
            state_nxt = ST_RUN;
          end
        end
        ST_RUN: begin
          if (sleep_r) begin
            state_nxt = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          // only a wake pin, or the reset pin checked above, leaves sleep
          if (wake) begin
            state_nxt = ST_WARM;
          end
        end
        default: begin
          state_nxt = ST_RESET;
        end
      endcase
    end
  end

  // state, settling counter and instruction-cycle divider
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r    <= ST_RESET;
      warm_cnt_r <= 13'h0000;
      div_r      <= 2'h0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_WARM) begin
        warm_cnt_r <= warm_cnt_r + 13'h0001;
      end else begin
        warm_cnt_r <= 13'h0000;
      end
      if (state_nxt == ST_RUN) begin
        div_r <= div_r + 2'h1;
      end else begin
        div_r <= 2'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write path and registers
  // ---------------------------------------------------------------
  reg                   aw_got_r;     // write address held
  reg  [9:0]            aw_idx_r;     // held word index
  reg                   w_got_r;      // write data held
  reg  [31:0]           w_data_r;     // held write data
  reg                   w_lane0_r;    // low byte lane strobe
  wire                  wr_fire;      // perform held write
  wire                  wr_ok;        // write index is mapped
  wire                  wr_en;        // low byte really written

  assign wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid_out;
  assign wr_ok   = (aw_idx_r == `IDX_P1_WAKE) |
                   (aw_idx_r == `IDX_OSC_MODE) |
                   (aw_idx_r == `IDX_T0_CTRL);
  assign wr_en   = wr_fire & wr_ok & w_lane0_r;

  // address and data taken in either order, answer after both
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `RESP_OKAY;
      aw_got_r          <= 1'b0;
      aw_idx_r          <= 10'h000;
      w_got_r           <= 1'b0;
      w_data_r          <= 32'h00000000;
      w_lane0_r         <= 1'b0;
    end else begin
      if (!aw_got_r && !s_axi_bvalid_out) begin
        s_axi_awready_out <= 1'b1;
      end
      if (!w_got_r && !s_axi_bvalid_out) begin
        s_axi_wready_out <= 1'b1;
      end
      if (s_axi_awready_out && s_axi_awvalid_in) begin
        aw_got_r          <= 1'b1;
        aw_idx_r          <= s_axi_awaddr_in[11:2];
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wready_out && s_axi_wvalid_in) begin
        w_got_r          <= 1'b1;
        w_data_r         <= s_axi_wdata_in;
        w_lane0_r        <= s_axi_wstrb_in[0];
        s_axi_wready_out <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_r         <= 1'b0;
        w_got_r          <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // software registers; reset pin clears them like power-on
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sleep_r  <= `RST_SLEEP;
      p1w_r    <= `RST_P1W;
      t0_en_r  <= `RST_T0_EN;
      t0_cnt_r <= `RST_T0_CNT;
    end else if (ext_rst) begin
      sleep_r  <= `RST_SLEEP;
      p1w_r    <= `RST_P1W;
      t0_en_r  <= `RST_T0_EN;
      t0_cnt_r <= `RST_T0_CNT;
    end else begin
      // sleep bit writes only land while instructions execute
      if (wr_en && aw_idx_r == `IDX_OSC_MODE && state_r == ST_RUN) begin
        sleep_r <= w_data_r[`SLEEP_BIT];
      end else if (state_r == ST_WARM && warm_cnt_r == WAKE_LAST) begin
        sleep_r <= 1'b0;
      end
      if (wr_en && aw_idx_r == `IDX_P1_WAKE) begin
        p1w_r <= w_data_r[`P1W_BITS-1:0];
      end
      if (wr_en && aw_idx_r == `IDX_T0_CTRL) begin
        t0_en_r <= w_data_r[`T0_EN_BIT];
      end
      // timer0 steps once per instruction cycle in normal mode
      if (t0_en_r && state_r == ST_RUN && div_r == `CPU_DIV_LAST) begin
        t0_cnt_r <= t0_cnt_r + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read path
  // ---------------------------------------------------------------
  reg  [31:0]           rd_data_nxt;  // read word for the index
  reg                   rd_ok_nxt;    // read index is mapped
  wire [9:0]            ar_idx;       // requested word index

  assign ar_idx = s_axi_araddr_in[11:2];

  // enable register is write-only and reads as zero
  always @* begin
    rd_data_nxt = 32'h00000000;
    rd_ok_nxt   = 1'b1;
    case (ar_idx)
      `IDX_P1_WAKE: begin
        rd_data_nxt = 32'h00000000;
      end
      `IDX_OSC_MODE: begin
        rd_data_nxt[`SLEEP_BIT] = sleep_r;
      end
      `IDX_T0_CTRL: begin
        rd_data_nxt[`T0_EN_BIT] = t0_en_r;
      end
      `IDX_T0_COUNT: begin
        rd_data_nxt[7:0] = t0_cnt_r;
      end
      `IDX_STATUS: begin
        rd_data_nxt[1:0] = state_r;
        rd_data_nxt[5:4] = HIGH_CLK_OPT;
      end
      default: begin
        rd_ok_nxt = 1'b0;
      end
    endcase
  end

  // one read in flight; data answered the cycle after acceptance
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= `RESP_OKAY;
    end else begin
      if (!s_axi_rvalid_out && !s_axi_arready_out) begin
        s_axi_arready_out <= 1'b1;
      end
      if (s_axi_arready_out && s_axi_arvalid_in) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rdata_out   <= rd_data_nxt;
        s_axi_rresp_out   <= rd_ok_nxt ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // clock and mode outputs
  // ---------------------------------------------------------------
  // mode outputs follow the next mode so they align with state_r; option outputs follow HIGH_CLK_OPT
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      osc_run_out        <= 1'b1;
      cpu_run_out        <= 1'b0;
      cpu_cycle_out      <= 1'b0;
      fcpu_clk_out       <= 1'b0;
      int_enable_out     <= 1'b0;
      xin_direct_clk_out <= 1'b0;
      crystal_output_pin_gpio_out      <= 1'b0;
      osc_high_drive_out <= 1'b0;
    end else begin
      osc_run_out        <= (state_nxt != ST_SLEEP);
      cpu_run_out        <= (state_nxt == ST_RUN);
      cpu_cycle_out      <= (state_nxt == ST_RUN) &&
                            (div_r == `CPU_DIV_LAST);
      fcpu_clk_out       <= (state_nxt == ST_RUN) & div_r[1];
      int_enable_out     <= (state_nxt == ST_RUN);
      xin_direct_clk_out <= (HIGH_CLK_OPT == `OPT_RC);
      crystal_output_pin_gpio_out      <= (HIGH_CLK_OPT == `OPT_RC);
      osc_high_drive_out <= (HIGH_CLK_OPT == `OPT_12M);
    end
  end

endmodule

// [clk_sleep_ctrl_tb_top.sv]
// self-checking bench for the clock, sleep and wakeup controller
`timescale 1ns/1ps
`include "clk_sleep_defs.vh"
module clk_sleep_ctrl_tb_top;
  localparam integer WK = 16;  // shortened settling count
  reg        clk_in, rstn_in, awvalid, wvalid, arvalid, bready, rready, b_late;
  reg [3:0]  wstrb;
  reg [11:0] awaddr, araddr;
  reg [31:0] wdata, cnt, fh;
  integer    n_errors, checked, w;
  wire       awready, wready, bvalid, arready, rvalid, osc_run, cpu_run, cpu_cycle, int_en, xin_clk, crystal_output_pin_io, drive;
  wire       fcpu;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] p0;
  wire [5:0] p1;
  wire       rst_pin_n;
  ext_pins_model pm (.clk_in(clk_in), .p0_out(p0), .p1_out(p1), .rst_pin_n_out(rst_pin_n));
  clk_sleep_ctrl #(.HIGH_CLK_OPT(`OPT_RC), .WAKE_CLKS(WK)) dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .rst_pin_n_in(rst_pin_n), .p0_pins_in(p0), .p1_pins_in(p1),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .osc_run_out(osc_run), .cpu_run_out(cpu_run), .cpu_cycle_out(cpu_cycle),
    .fcpu_clk_out(fcpu), .int_enable_out(int_en), .xin_direct_clk_out(xin_clk), .crystal_output_pin_gpio_out(crystal_output_pin_io),
    .osc_high_drive_out(drive));
  // verdict and end of run
  task summarize;
    begin
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task to_fail;
    begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t wait timed out", $time);
      summarize;
    end
  endtask
  // word compare, four-state exact
  task chk_word(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_bit(input got, input exp);
    begin
      chk_word({31'h0, got}, {31'h0, exp});
    end
  endtask
  // axi4-lite write; bready raised once both channels are taken (or once bvalid shows, when b_late)
  task axi_wr(input [9:0] idx, input [31:0] d, input [1:0] er);
    integer k;
    reg     a_d, w_d, b_d;
    begin
      a_d = 0; w_d = 0; b_d = 0;
      awaddr <= {idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (k = 0; k < 40 && !b_d; k = k + 1) begin
        @(posedge clk_in);
        if (bvalid && bready) begin b_d = 1; bready <= 1'b0; chk_word({30'h0, bresp}, {30'h0, er}); end
        if (awready && !a_d) begin a_d = 1; awvalid <= 1'b0; end
        if (wready && !w_d) begin w_d = 1; wvalid <= 1'b0; end
        if (a_d && w_d && !b_d && (!b_late || bvalid)) bready <= 1'b1;
      end
      if (!b_d) to_fail;
    end
  endtask
  // axi4-lite read with expected data and response
  task axi_rd(input [9:0] idx, input [31:0] ed, input [1:0] er);
    integer k;
    reg     a_d, r_d;
    begin
      a_d = 0; r_d = 0;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      for (k = 0; k < 40 && !r_d; k = k + 1) begin
        @(posedge clk_in);
        if (rvalid && rready) begin
          r_d = 1;
          rready <= 1'b0;
          chk_word(rdata, ed);
          chk_word({30'h0, rresp}, {30'h0, er});
        end
        if (arready && !a_d) begin a_d = 1; arvalid <= 1'b0; rready <= 1'b1; end
      end
      if (!r_d) to_fail;
    end
  endtask
  // bounded wait for run level
  task wait_run(input v, input integer n);
    integer k;
    begin
      for (k = 0; k < n && cpu_run !== v; k = k + 1) @(posedge clk_in);
      if (cpu_run !== v) to_fail;
    end
  endtask
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    n_errors = 0; checked = 0; rstn_in = 1'b0; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0;
    awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0;
    bready = 1'b0; rready = 1'b0; wstrb = 4'hF; b_late = 1'b0;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    wait_run(1, 100);
    cnt = 0;
    fh = 0;
    repeat (40) begin @(posedge clk_in); cnt = cnt + cpu_cycle; fh = fh + fcpu; end
    chk_word(cnt, 32'hA);
    chk_word(fh, 32'h14);
    chk_bit(crystal_output_pin_io, 1'b1);
    chk_bit(xin_clk, 1'b1);
    chk_bit(drive, 1'b0);
    axi_rd(`IDX_STATUS, 32'h2, `RESP_OKAY);
    axi_rd(`IDX_P1_WAKE, 32'h0, `RESP_OKAY);
    axi_rd(`IDX_OSC_MODE, 32'h0, `RESP_OKAY);
    axi_rd(10'h3FF, 32'h0, `RESP_SLVERR);
    axi_wr(`IDX_STATUS, 32'hFF, `RESP_SLVERR);
    axi_rd(`IDX_T0_COUNT, 32'h0, `RESP_OKAY);
    // align to an instruction cycle so the timer count is exact
    @(posedge clk_in);
    for (w = 0; w < 8 && cpu_cycle !== 1'b1; w = w + 1) @(posedge clk_in);
    if (cpu_cycle !== 1'b1) to_fail;
    axi_wr(`IDX_T0_CTRL, 32'h1, `RESP_OKAY);
    repeat (40) @(posedge clk_in);
    axi_wr(`IDX_T0_CTRL, 32'h0, `RESP_OKAY);
    axi_rd(`IDX_T0_COUNT, 32'hB, `RESP_OKAY);
    repeat (20) @(posedge clk_in);
    axi_rd(`IDX_T0_COUNT, 32'hB, `RESP_OKAY);
    axi_rd(`IDX_T0_CTRL, 32'h0, `RESP_OKAY);
    // low byte lane off: sleep write must not land; late bready holds the response
    wstrb <= 4'h0;
    b_late = 1'b1;
    axi_wr(`IDX_OSC_MODE, 32'h8, `RESP_OKAY);
    wstrb <= 4'hF;
    b_late = 1'b0;
    repeat (4) @(posedge clk_in);
    chk_bit(cpu_run, 1'b1);
    $display("test registers done");
    axi_wr(`IDX_OSC_MODE, 32'h8, `RESP_OKAY);
    wait_run(0, 8);
    chk_bit(osc_run, 1'b0);
    chk_bit(int_en, 1'b0);
    axi_rd(`IDX_OSC_MODE, 32'h8, `RESP_OKAY);
    pm.flip_p1(5);
    repeat (30) @(posedge clk_in);
    chk_bit(osc_run, 1'b0);
    axi_wr(`IDX_P1_WAKE, 32'h20, `RESP_OKAY);
    pm.flip_p1(5);
    repeat (8) @(posedge clk_in);
    chk_bit(osc_run, 1'b1);
    chk_bit(cpu_run, 1'b0);
    wait_run(1, WK + 8);
    axi_rd(`IDX_OSC_MODE, 32'h0, `RESP_OKAY);
    $display("test port 1 wake done");
    axi_wr(`IDX_OSC_MODE, 32'h8, `RESP_OKAY);
    wait_run(0, 8);
    pm.flip_p0(7);
    wait_run(1, WK + 16);
    $display("test port 0 wake done");
    pm.pulse_rst(8);
    chk_bit(cpu_run, 1'b0);
    wait_run(1, WK + 20);
    axi_rd(`IDX_T0_COUNT, 32'h0, `RESP_OKAY);
    axi_wr(`IDX_OSC_MODE, 32'h8, `RESP_OKAY);
    wait_run(0, 8);
    pm.flip_p1(5);
    repeat (30) @(posedge clk_in);
    chk_bit(osc_run, 1'b0);
    pm.flip_p0(0);
    wait_run(1, WK + 16);
    $display("test reset pin done");
    summarize;
  end
endmodule

// [clk_sleep_defs.vh]
// constants for the clock, sleep and wakeup controller
`ifndef CLK_SLEEP_DEFS_VH
`define CLK_SLEEP_DEFS_VH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define IDX_P1_WAKE   10'h0C0
`define IDX_OSC_MODE  10'h0CA
`define IDX_T0_CTRL   10'h0D0
`define IDX_T0_COUNT  10'h0D1
`define IDX_STATUS    10'h0D2

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define SLEEP_BIT     3
`define T0_EN_BIT     0
`define P1W_BITS      6
`define RST_P1W       6'h00
`define RST_SLEEP     1'b0
`define RST_T0_EN     1'b0
`define RST_T0_CNT    8'h00

// ---------------------------------------------------------------
// timing counts
// ---------------------------------------------------------------
`define CPU_DIV_LAST  2'h3
`define WAKE_CLKS     4096

// ---------------------------------------------------------------
// high clock option codes
// ---------------------------------------------------------------
`define OPT_RC        2'h0
`define OPT_12M       2'h1
`define OPT_4M        2'h2

// ---------------------------------------------------------------
// bus responses
// ---------------------------------------------------------------
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// [ext_pins_model.sv]
// far-side model: port pins and external reset pin seen by the controller
`timescale 1ns/1ps
module ext_pins_model (
  input  wire       clk_in,
  output reg  [7:0] p0_out,
  output reg  [5:0] p1_out,
  output reg        rst_pin_n_out
);
  // pins idle low, reset pin released
  initial begin
    p0_out = 8'h00;
    p1_out = 6'h00;
    rst_pin_n_out = 1'b1;
  end
  // one port 0 level change just after an edge
  task flip_p0(input integer i);
    begin
      @(posedge clk_in);
      p0_out[i] <= ~p0_out[i];
    end
  endtask
  // one port 1 level change just after an edge
  task flip_p1(input integer i);
    begin
      @(posedge clk_in);
      p1_out[i] <= ~p1_out[i];
    end
  endtask
  // reset pin held low for n cycles, then released
  task pulse_rst(input integer n);
    begin
      @(posedge clk_in);
      rst_pin_n_out <= 1'b0;
      repeat (n) @(posedge clk_in);
      rst_pin_n_out <= 1'b1;
    end
  endtask
endmodule
